// File: rtl/tsm_regs.svh
`ifndef TSM_REGS_SVH
`define TSM_REGS_SVH

`define TSM_ADDR_STATUS_TWO 8'h21
`define TSM_ADDR_LV_HIGH 8'h23
`define TSM_ADDR_LV_LOW 8'h24
`define TSM_ADDR_PATH_HIGH 8'h25
`define TSM_ADDR_PATH_LOW 8'h26
`define TSM_ADDR_MASK_TWO 8'h6f
`define TSM_ADDR_MASK_ONE 8'h7f

`define TSM_BIT_RX_MF 7
`define TSM_BIT_TX_MF 6
`define TSM_BIT_SEC 5
`define TSM_BIT_RX_FULL 4
`define TSM_BIT_TX_EMPTY 3
`define TSM_BIT_MATCH 2
`define TSM_BIT_ABORT 1
`define TSM_BIT_SYNC_LOST 0

`define TSM_MASK_RESET 8'h00
`define TSM_STATUS_RESET 8'h00
`define TSM_READ_IDLE 8'h00

`define TSM_SEC_SHORT_MS 999
`define TSM_SEC_LONG_MS 1002
`define TSM_RX_RATE_KHZ 1544
`define TSM_SEC_SHORT_CYC (`TSM_SEC_SHORT_MS * `TSM_RX_RATE_KHZ)
`define TSM_SEC_LONG_CYC (`TSM_SEC_LONG_MS * `TSM_RX_RATE_KHZ)

`define TSM_ZERO_RUN_PLAIN 16
`define TSM_ZERO_RUN_B8ZS 8
`define TSM_ABORT_ONES 8
`define TSM_LV_WIDTH 16
`define TSM_PATH_WIDTH 12

`endif

// File: rtl/tsm_pkg.sv
package tsm_pkg;
    typedef enum logic [1:0] {
        SEC_FIRST,
        SEC_SECOND,
        SEC_THIRD
    } tsm_sec_phase_t;
    typedef logic [7:0] tsm_byte_t;
endpackage

// File: rtl/tsm_sat_counter.sv
`timescale 1ns/1ns
module tsm_sat_counter #(
    parameter int WIDTH = 16
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic inc_i,
    input wire logic tick_i,
    output logic [WIDTH-1:0] held_o
);
    logic [WIDTH-1:0] acc_r;
    logic [WIDTH-1:0] held_r;
    logic [WIDTH-1:0] acc_nxt;

    // An error in the tick cycle opens the new second
    always_comb begin
        if (tick_i) begin
            acc_nxt = {{(WIDTH-1){1'b0}}, inc_i};
        end else if (inc_i && acc_r != {WIDTH{1'b1}}) begin
            acc_nxt = acc_r + {{(WIDTH-1){1'b0}}, 1'b1};
        end else begin
            acc_nxt = acc_r;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            acc_r <= '0;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            held_r <= '0;
        end else if (tick_i) begin
            held_r <= acc_r;
        end
    end

    assign held_o = held_r;

    chk_hold_latch: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) tick_i |=> held_r == $past(acc_r))
        else $error("held count not latched on tick");
    chk_sat_stop: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        acc_r == {WIDTH{1'b1}} && !tick_i |=> acc_r == {WIDTH{1'b1}})
        else $error("counter wrapped past maximum");
    chk_held_stable: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) !tick_i |=> $stable(held_r))
        else $error("held count changed between ticks");
endmodule // tsm_sat_counter

// File: rtl/tsm_status_mask.sv
`timescale 1ns/1ns
`include "tsm_regs.svh"
module tsm_status_mask
    import tsm_pkg::*;
#(
    parameter int SEC_SHORT_CYC = `TSM_SEC_SHORT_CYC,
    parameter int SEC_LONG_CYC = `TSM_SEC_LONG_CYC,
    parameter int LV_WIDTH = `TSM_LV_WIDTH,
    parameter int PATH_WIDTH = `TSM_PATH_WIDTH
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    input wire logic rx_clk_en_i,
    input wire logic rx_mf_bound_i,
    input wire logic tx_mf_bound_i,
    input wire logic rx_link_bit_en_i,
    input wire logic rx_link_bit_i,
    input wire logic tx_link_empty_i,
    input wire logic [7:0] link_match_byte_a_i,
    input wire logic [7:0] link_match_byte_b_i,
    input wire logic [7:0] status_one_i,
    input wire logic bpv_i,
    input wire logic b8zs_code_i,
    input wire logic rx_bit_zero_i,
    input wire logic crc_err_i,
    input wire logic ft_err_i,
    input wire logic fs_err_i,
    input wire logic excess_zero_en_i,
    input wire logic b8zs_en_i,
    input wire logic esf_mode_i,
    input wire logic count_fs_i,
    output logic [7:0] rx_link_byte_o,
    output logic one_second_tick_o,
    output logic irq_out_one_n_o,
    output logic irq_out_two_n_o
);
    localparam logic [4:0] ZRUN_PLAIN = 5'(`TSM_ZERO_RUN_PLAIN);
    localparam logic [4:0] ZRUN_B8ZS = 5'(`TSM_ZERO_RUN_B8ZS);
    localparam logic [3:0] ABORT_ONES = 4'(`TSM_ABORT_ONES);

    tsm_byte_t status_two_r;
    tsm_byte_t status_two_nxt;
    tsm_byte_t status_set;
    tsm_byte_t interrupt_mask_one_r;
    tsm_byte_t interrupt_mask_two_r;
    tsm_byte_t rdata_r;
    tsm_byte_t rdata_nxt;
    tsm_byte_t link_shift_r;
    tsm_byte_t link_shift_nxt;
    tsm_byte_t rx_link_byte_r;
    logic [2:0] link_bits_r;
    logic [3:0] ones_run_r;
    logic [4:0] zero_run_r;
    logic [31:0] sec_count_r;
    tsm_sec_phase_t sec_phase_r;
    logic sec_tick;
    logic sec_tick_r;
    logic [31:0] sec_limit;
    logic byte_done;
    logic match_hit;
    logic abort_hit;
    logic zero_hit;
    logic lv_inc;
    logic path_inc;
    logic irq_one_n_r;
    logic irq_two_n_r;
    logic [LV_WIDTH-1:0] lv_held;
    logic [PATH_WIDTH-1:0] path_held;

    // One-second timer paced by the receive line clock
    always_comb begin
        unique case (sec_phase_r)
            SEC_FIRST: sec_limit = SEC_SHORT_CYC - 1;
            SEC_SECOND: sec_limit = SEC_SHORT_CYC - 1;
            SEC_THIRD: sec_limit = SEC_LONG_CYC - 1;
            default: sec_limit = SEC_SHORT_CYC - 1;
        endcase
    end

    assign sec_tick = rx_clk_en_i && sec_count_r == sec_limit;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sec_count_r <= '0;
            sec_phase_r <= SEC_FIRST;
        end else if (sec_tick) begin
            sec_count_r <= '0;
            unique case (sec_phase_r)
                SEC_FIRST: sec_phase_r <= SEC_SECOND;
                SEC_SECOND: sec_phase_r <= SEC_THIRD;
                SEC_THIRD: sec_phase_r <= SEC_FIRST;
                default: sec_phase_r <= SEC_FIRST;
            endcase
        end else if (rx_clk_en_i) begin
            sec_count_r <= sec_count_r + 32'h1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sec_tick_r <= 1'b0;
        end else begin
            sec_tick_r <= sec_tick;
        end
    end

    // Receive link bits arrive least significant first
    assign link_shift_nxt = {rx_link_bit_i, link_shift_r[7:1]};
    assign byte_done = rx_link_bit_en_i && link_bits_r == 3'h7;
    assign match_hit = byte_done &&
        (link_shift_nxt == link_match_byte_a_i ||
         link_shift_nxt == link_match_byte_b_i);
    assign abort_hit = rx_link_bit_en_i && rx_link_bit_i &&
        ones_run_r == ABORT_ONES - 4'h1;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            link_shift_r <= '0;
            link_bits_r <= '0;
        end else if (rx_link_bit_en_i) begin
            link_shift_r <= link_shift_nxt;
            link_bits_r <= link_bits_r + 3'h1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rx_link_byte_r <= '0;
        end else if (byte_done) begin
            rx_link_byte_r <= link_shift_nxt;
        end
    end

    // Run stops at eight so a long abort flags only once
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ones_run_r <= '0;
        end else if (rx_link_bit_en_i) begin
            if (!rx_link_bit_i) begin
                ones_run_r <= '0;
            end else if (ones_run_r != ABORT_ONES) begin
                ones_run_r <= ones_run_r + 4'h1;
            end
        end
    end

    // Status flags: hardware set wins over clear-on-read
    always_comb begin
        status_set = '0;
        status_set[`TSM_BIT_RX_MF] = rx_mf_bound_i;
        status_set[`TSM_BIT_TX_MF] = tx_mf_bound_i;
        status_set[`TSM_BIT_SEC] = sec_tick;
        status_set[`TSM_BIT_RX_FULL] = byte_done;
        status_set[`TSM_BIT_TX_EMPTY] = tx_link_empty_i;
        status_set[`TSM_BIT_MATCH] = match_hit;
        status_set[`TSM_BIT_ABORT] = abort_hit;
        status_two_nxt = status_two_r;
        if (rd_i && addr_i == `TSM_ADDR_STATUS_TWO) begin
            status_two_nxt = '0;
        end
        status_two_nxt = status_two_nxt | status_set;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            status_two_r <= `TSM_STATUS_RESET;
        end else begin
            status_two_r <= status_two_nxt;
        end
    end

    // Bit zero of mask two is unassigned and held at zero
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            interrupt_mask_one_r <= `TSM_MASK_RESET;
            interrupt_mask_two_r <= `TSM_MASK_RESET;
        end else if (wr_i) begin
            if (addr_i == `TSM_ADDR_MASK_ONE) begin
                interrupt_mask_one_r <= wdata_i;
            end
            if (addr_i == `TSM_ADDR_MASK_TWO) begin
                interrupt_mask_two_r <= {wdata_i[7:1], 1'b0};
            end
        end
    end

    // Interrupts follow the flags one cycle later, active low
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            irq_one_n_r <= 1'b1;
            irq_two_n_r <= 1'b1;
        end else begin
            irq_one_n_r <= ~|(status_one_i & interrupt_mask_one_r);
            irq_two_n_r <= ~|(status_two_r &
                interrupt_mask_two_r);
        end
    end

    // Excessive zeros: one count as the run reaches its length
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            zero_run_r <= '0;
        end else if (rx_clk_en_i) begin
            if (!rx_bit_zero_i) begin
                zero_run_r <= '0;
            end else if (zero_run_r != ZRUN_PLAIN) begin
                zero_run_r <= zero_run_r + 5'h1;
            end
        end
    end

    assign zero_hit = excess_zero_en_i && rx_clk_en_i && rx_bit_zero_i &&
        zero_run_r == (b8zs_en_i ? ZRUN_B8ZS : ZRUN_PLAIN) - 5'h1;
    // No sync-loss term here: the line count never pauses
    assign lv_inc = (bpv_i && !(b8zs_en_i && b8zs_code_i))
        || zero_hit;
    assign path_inc = !status_one_i[`TSM_BIT_SYNC_LOST] &&
        (esf_mode_i ? crc_err_i
                    : (ft_err_i || (count_fs_i && fs_err_i)));

    tsm_sat_counter #(
        .WIDTH(LV_WIDTH)
    ) u_line_violation_counter (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .inc_i(lv_inc),
        .tick_i(sec_tick),
        .held_o(lv_held)
    );

    tsm_sat_counter #(
        .WIDTH(PATH_WIDTH)
    ) u_path_error_counter (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .inc_i(path_inc),
        .tick_i(sec_tick),
        .held_o(path_held)
    );

    // Read port; the path high register reads its upper four bits as zero
    always_comb begin
        rdata_nxt = `TSM_READ_IDLE;
        unique case (addr_i)
            `TSM_ADDR_STATUS_TWO: rdata_nxt = status_two_r;
            `TSM_ADDR_LV_HIGH: rdata_nxt = lv_held[15:8];
            `TSM_ADDR_LV_LOW: rdata_nxt = lv_held[7:0];
            `TSM_ADDR_PATH_HIGH:
                rdata_nxt = {4'h0, path_held[11:8]};
            `TSM_ADDR_PATH_LOW: rdata_nxt = path_held[7:0];
            `TSM_ADDR_MASK_TWO: rdata_nxt = interrupt_mask_two_r;
            `TSM_ADDR_MASK_ONE: rdata_nxt = interrupt_mask_one_r;
            default: rdata_nxt = `TSM_READ_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rdata_r <= `TSM_READ_IDLE;
        end else if (rd_i) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o = rdata_r;
    assign rx_link_byte_o = rx_link_byte_r;
    assign one_second_tick_o = sec_tick_r;
    assign irq_out_one_n_o = irq_one_n_r;
    assign irq_out_two_n_o = irq_two_n_r;

    chk_rx_mf_flag: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) rx_mf_bound_i |=> status_two_r[7])
        else $error("receive multiframe flag not set");
    chk_tx_mf_flag: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) tx_mf_bound_i |=> status_two_r[6])
        else $error("transmit multiframe flag not set");
    chk_sec_interval: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        sec_tick |=> sec_count_r == '0 && status_two_r[5])
        else $error("second tick did not restart timer");
    chk_full_flag: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        byte_done |=> status_two_r[4] &&
        rx_link_byte_r == $past(link_shift_nxt))
        else $error("link byte not captured with full flag");
    chk_empty_flag: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) tx_link_empty_i |=> status_two_r[3])
        else $error("transmit empty flag not set");
    chk_match_flag: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        byte_done && link_shift_nxt == link_match_byte_a_i
        |=> status_two_r[2])
        else $error("match flag not set");
    chk_match_b_flag: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        byte_done && link_shift_nxt == link_match_byte_b_i
        |=> status_two_r[2])
        else $error("second match byte not flagged");
    chk_set_wins: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        rd_i && addr_i == `TSM_ADDR_STATUS_TWO
        |=> (status_two_r & $past(status_set)) == $past(status_set))
        else $error("status set lost to clear on read");
    chk_abort_flag: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) abort_hit |=> status_two_r[1])
        else $error("abort flag not set");
    chk_mask_zero: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) !interrupt_mask_two_r[0] && !status_two_r[0])
        else $error("unassigned bit became set");
    chk_irq_one_gate: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        |(status_one_i & interrupt_mask_one_r) |=> !irq_out_one_n_o)
        else $error("first interrupt not asserted");
    chk_irq_two_hold: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        ##1 irq_out_two_n_o == !$past(|(status_two_r & interrupt_mask_two_r)))
        else $error("second interrupt disagrees with flags");
    chk_full_irq: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        byte_done && interrupt_mask_two_r[4] && !wr_i |=> ##1 !irq_out_two_n_o)
        else $error("buffer full did not raise interrupt");
    chk_path_halt: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) status_one_i[0] |-> !path_inc)
        else $error("path error counted while sync lost");
    chk_lv_always: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) bpv_i && !b8zs_en_i |-> lv_inc)
        else $error("line violation dropped");
    chk_lv_read: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        rd_i && addr_i == `TSM_ADDR_LV_LOW |=> rdata_o == $past(lv_held[7:0]))
        else $error("line count low byte misread");
    chk_path_high: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) rd_i && addr_i == `TSM_ADDR_PATH_HIGH
        |=> rdata_o == {4'h0, $past(path_held[11:8])})
        else $error("path count high nibble misread");

    cov_sec_tick: cover property (@(posedge core_clk_i) sec_tick);
    cov_match: cover property (@(posedge core_clk_i) match_hit);
    cov_abort: cover property (@(posedge core_clk_i) abort_hit);
    cov_zero_hit: cover property (@(posedge core_clk_i) zero_hit);
    cov_read_set: cover property (@(posedge core_clk_i)
        rd_i && addr_i == `TSM_ADDR_STATUS_TWO && |status_set);
endmodule // tsm_status_mask

// File: testbench/tsm_line_model.sv
`timescale 1ns/1ns
module tsm_line_model (
    input wire logic core_clk_i,
    output logic rx_clk_en_o,
    output logic link_en_o,
    output logic link_bit_o
);
    logic [1:0] div_r;
    initial begin
        div_r = 2'h0;
        rx_clk_en_o = 1'b0;
        link_en_o = 1'b0;
        link_bit_o = 1'b0;
    end
    // Line bit pace: one slot in four core cycles, free running
    always @(negedge core_clk_i) begin
        div_r <= div_r + 2'h1;
        rx_clk_en_o <= (div_r == 2'h3);
    end
    // LSB first; between bits the line shows the inverse so stale data
    // can never pass for a valid bit
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            repeat (3) @(negedge core_clk_i);
            link_en_o = 1'b1;
            link_bit_o = b[i];
            @(negedge core_clk_i);
            link_en_o = 1'b0;
            link_bit_o = ~b[i];
        end
    endtask
endmodule // tsm_line_model

// File: testbench/tsm_status_mask_tb.sv
`timescale 1ns/1ns
module tsm_status_mask_tb
    import tsm_pkg::*;
;
    logic core_clk_i, rst_n_i, wr, rd, rx_mf, tx_mf, tx_emp, bpv, b8c, zr;
    logic crc, ft, fs, ez, b8, esf, cfs, rx_en, l_en, l_bit;
    logic tick, irq1_n, irq2_n;
    tsm_byte_t addr, wdata, rdata, ma, mb, st1, lbyte, v;
    int n_mismatch, num_checks, ecnt;
    int ivl[$];

    tsm_status_mask #(.SEC_SHORT_CYC(20), .SEC_LONG_CYC(23))
        i_tsm_status_mask (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr),
        .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata),
        .rx_clk_en_i(rx_en), .rx_mf_bound_i(rx_mf), .tx_mf_bound_i(tx_mf),
        .rx_link_bit_en_i(l_en), .rx_link_bit_i(l_bit),
        .tx_link_empty_i(tx_emp), .link_match_byte_a_i(ma),
        .link_match_byte_b_i(mb), .status_one_i(st1), .bpv_i(bpv),
        .b8zs_code_i(b8c), .rx_bit_zero_i(zr), .crc_err_i(crc),
        .ft_err_i(ft), .fs_err_i(fs), .excess_zero_en_i(ez),
        .b8zs_en_i(b8), .esf_mode_i(esf), .count_fs_i(cfs),
        .rx_link_byte_o(lbyte), .one_second_tick_o(tick),
        .irq_out_one_n_o(irq1_n), .irq_out_two_n_o(irq2_n));

    tsm_line_model i_tsm_line_model (.core_clk_i(core_clk_i),
        .rx_clk_en_o(rx_en), .link_en_o(l_en), .link_bit_o(l_bit));

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // Line slots seen per second, for the interval pattern
    always @(posedge core_clk_i) begin
        if (rst_n_i !== 1'b1) begin
            ecnt = 0;
        end else if (tick === 1'b1) begin
            ivl.push_back(ecnt);
            ecnt = 0;
        end else if (rx_en === 1'b1) begin
            ecnt = ecnt + 1;
        end
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input tsm_byte_t a, input tsm_byte_t d);
        @(negedge core_clk_i);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge core_clk_i);
        wr = 1'b0;
    endtask

    task automatic rd_reg(input tsm_byte_t a, output tsm_byte_t d);
        @(negedge core_clk_i);
        addr = a;
        rd = 1'b1;
        @(negedge core_clk_i);
        rd = 1'b0;
        @(negedge core_clk_i);
        d = rdata;
    endtask

    task automatic pulse(ref logic s, input int n);
        repeat (n) begin
            @(negedge core_clk_i);
            s = 1'b1;
            @(negedge core_clk_i);
            s = 1'b0;
        end
    endtask

    // Returns once the slot counter has restarted for the new second
    task automatic wait_tick;
        int i;
        i = 0;
        do begin
            @(negedge core_clk_i);
            i++;
        end while (tick !== 1'b1 && i < 200);
        if (i >= 200) begin
            n_mismatch++;
            $display("BAD t=%0t no second tick", $time);
            test_done();
        end
        @(negedge core_clk_i);
    endtask

    // m = {esf, count fs, excess zeros, b8zs, sync lost}
    task automatic sec_row(input logic [4:0] m, input int nbpv, nb8, ncrc,
                           input int nft, nfs, nz, input tsm_byte_t elv, ep);
        int i;
        wait_tick();
        {esf, cfs, ez, b8, st1[0]} = m;
        zr = (nz > 0);
        pulse(bpv, nbpv);
        b8c = 1'b1;
        pulse(bpv, nb8);
        b8c = 1'b0;
        pulse(crc, ncrc);
        pulse(ft, nft);
        pulse(fs, nfs);
        for (i = 0; i < 200 && ecnt < nz; i++) @(negedge core_clk_i);
        if (i >= 200) begin
            n_mismatch++;
            $display("BAD t=%0t zero run not reached", $time);
            test_done();
        end
        zr = 1'b0;
        st1[0] = 1'b0;
        wait_tick();
        rd_reg(8'h23, v);
        check(v, 8'h00);
        rd_reg(8'h24, v);
        check(v, elv);
        rd_reg(8'h25, v);
        check(v, 8'h00);
        rd_reg(8'h26, v);
        check(v, ep);
    endtask

    tsm_byte_t ra[8] = '{8'h21, 8'h23, 8'h24, 8'h25, 8'h26, 8'h6f, 8'h7f,
        8'h22};
    tsm_byte_t lb[3] = '{8'ha5, 8'h3c, 8'hff};
    tsm_byte_t ls[3] = '{8'h14, 8'h14, 8'h12};
    int eb[3] = '{7, 6, 3};

    initial begin
        {wr, rd, rx_mf, tx_mf, tx_emp, bpv, b8c, zr} = '0;
        {crc, ft, fs, ez, b8, esf, cfs} = '0;
        {addr, wdata, st1} = '0;
        ma = 8'ha5;
        mb = 8'h3c;
        n_mismatch = 0;
        num_checks = 0;
        rst_n_i = 1'b0;
        repeat (3) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        check({6'h0, irq1_n, irq2_n}, 8'h03);
        foreach (ra[i]) begin
            rd_reg(ra[i], v);
            check(v, 8'h00);
        end
        wr_reg(8'h6f, 8'hff);
        rd_reg(8'h6f, v);
        check(v, 8'hfe);
        wr_reg(8'h7f, 8'ha5);
        rd_reg(8'h7f, v);
        check(v, 8'ha5);
        st1 = 8'h5a;
        repeat (3) @(negedge core_clk_i);
        check({7'h0, irq1_n}, 8'h01);
        st1 = 8'h84;
        repeat (3) @(negedge core_clk_i);
        check({7'h0, irq1_n}, 8'h00);
        st1 = 8'h00;
        foreach (eb[i]) begin
            wr_reg(8'h6f, 8'h00);
            rd_reg(8'h21, v);
            if (eb[i] == 7) pulse(rx_mf, 1);
            else if (eb[i] == 6) pulse(tx_mf, 1);
            else pulse(tx_emp, 1);
            repeat (3) @(negedge core_clk_i);
            check({7'h0, irq2_n}, 8'h01);
            wr_reg(8'h6f, 8'h01 << eb[i]);
            repeat (2) @(negedge core_clk_i);
            check({7'h0, irq2_n}, 8'h00);
            rd_reg(8'h21, v);
            check(v & 8'hdf, 8'h01 << eb[i]);
            repeat (3) @(negedge core_clk_i);
            check({7'h0, irq2_n}, 8'h01);
        end
        wr_reg(8'h6f, 8'h10);
        rd_reg(8'h21, v);
        foreach (lb[i]) begin
            i_tsm_line_model.send_byte(lb[i]);
            repeat (3) @(negedge core_clk_i);
            check(lbyte, lb[i]);
            check({7'h0, irq2_n}, 8'h00);
            rd_reg(8'h21, v);
            check(v & 8'h16, ls[i]);
        end
        sec_row(5'b10010, 3, 1, 2, 1, 1, 0, 8'h03, 8'h02);
        sec_row(5'b01000, 1, 0, 1, 1, 1, 0, 8'h01, 8'h02);
        sec_row(5'b00100, 0, 0, 0, 1, 1, 16, 8'h01, 8'h01);
        sec_row(5'b00110, 0, 0, 0, 0, 0, 8, 8'h01, 8'h00);
        sec_row(5'b10001, 2, 0, 3, 0, 0, 0, 8'h02, 8'h00);
        check(8'(ivl.size() >= 4), 8'h01);
        for (int i = 0; i < 4 && i < ivl.size(); i++) begin
            check(8'(ivl[i]), (i % 3 == 2) ? 8'h17 : 8'h14);
        end
        test_done();
    end
endmodule // tsm_status_mask_tb
